// *** rtl/dcc_defs.vh ***
// Purpose: Constants for the eight-channel DMA channel control block
// Assumes: Byte-addressed classic Wishbone, 32-bit data
// Notes:   Offsets are byte addresses on the bus
`ifndef DCC_DEFS_VH
`define DCC_DEFS_VH
`define DCC_CHCTL_BASE     8'h00
`define DCC_OPER_OFF       8'h20
`define DCC_CHSTAT_OFF     8'h24
`define DCC_CHCTL_RESET    32'h00000000
`define DCC_OPER_RESET     32'h00000000
`define DCC_SSA_HI         31
`define DCC_SSA_LO         29
`define DCC_STC_BIT        28
`define DCC_DSA_HI         27
`define DCC_DSA_LO         25
`define DCC_DTC_BIT        24
`define DCC_RSV_MASK       32'h00F00000
`define DCC_DS_BIT         19
`define DCC_RL_BIT         18
`define DCC_AM_BIT         17
`define DCC_AL_BIT         16
`define DCC_DM_HI          15
`define DCC_DM_LO          14
`define DCC_SM_HI          13
`define DCC_SM_LO          12
`define DCC_RS_HI          11
`define DCC_RS_LO          8
`define DCC_TM_BIT         7
`define DCC_TS_HI          6
`define DCC_TS_LO          4
`define DCC_QCL_BIT        3
`define DCC_IE_BIT         2
`define DCC_TE_BIT         1
`define DCC_DE_BIT         0
`define DCC_OPER_DDT_BIT   15
`define DCC_OPER_DBL_BIT   14
`define DCC_OPER_AE_BIT    2
`define DCC_OPER_NMI_SEEN_FLAG_BIT  1
`define DCC_OPER_DME_BIT   0
`define DCC_OPER_MASK      32'h0000C001
`define DCC_HI_CH_MASK     32'hFF0AFFF7
`define DCC_LO_CH_MASK     32'hFF0FFFF7
`endif

// *** rtl/dcc_channel_control.v ***
// Purpose: Channel control registers and gating for an eight-channel DMA controller
// Assumes: Classic Wishbone slave, one clock, synchronous active-high reset
// Notes:   Arbitration and address engines sit outside; they consume the decoded fields
`timescale 1ns/1ps
`include "dcc_defs.vh"

// Register map, byte addresses on the bus
//   0x00 + 4*n  control register of channel n, n = 0..7
//   0x20        controller-wide operation register
//   0x24        status, read only, bit n = channel n running
//   others      read zero, writes dropped, still acknowledged
//
// Channel control register fields
//   31:29  source space attribute, card areas only
//   28     source wait register select
//   27:25  destination space attribute, card areas only
//   24     destination wait register select
//   23:20  reserved, read zero
//   19     request sampling select, level or edge
//   18     accept strobe polarity, 1 = high (ch 0-1)
//   17     ack phase, 0 = read cycle, 1 = write cycle
//   16     ack polarity, 1 = high (ch 0-1)
//   15:14  destination address step
//   13:12  source address step
//   11:8   request source select
//   7      bus mode, burst or cycle steal
//   6:4    access size
//   3      queue flush strobe, never stored
//   2      end-of-count interrupt enable
//   1      count done flag, hardware set
//   0      channel enable
//
// Operation register fields kept here
//   15     on-demand mode
//   14     eight-channel selection
//   2      address fault flag
//   1      non-maskable interrupt flag
//   0      master enable
//
// Flag clearing
//   A flag clears only when zero is written after a
//   full-word read saw it at one. Writing one keeps it.
//   A hardware set in the same cycle as a clear wins,
//   so a completion is never lost.
//
// Timing
//   A write lands on the edge that takes the request;
//   decoded outputs follow one cycle later. A read
//   answers one cycle after the request.
//   Status lags the enables by one cycle.
//
// Outputs
//   Every output comes from a flop, so the engine sees
//   no decode glitches; the price is one cycle of lag.
//   In normal mode only channels 0 and 1 have pins,
//   so only they honour the polarity bits.
//
// Faults
//   Fault inputs are one-cycle pulses. Either sets its
//   flag on the next edge and drops the running state
//   of all channels one edge later. Channels stay idle
//   until software clears the flag.
//
// Queue flush
//   A full-word write with bit 3 set gives a one-cycle
//   pulse on that channel's flush output, only in
//   on-demand mode with eight channels selected.
//
// Reset
//   Synchronous, active high; everything goes to zero.
//   Low-power modes are not seen here, so contents stay.
//
// Limitations
//   Priority bits belong to the arbiter, not here.
//   Narrow accesses are acknowledged but do nothing.
//   The status word is read only.
//   Abort inputs only mask a completion in that cycle.

module dcc_channel_control #(
    parameter NCH = 8
) (
    // Clock, reset and register bus
    input  wire            clk_i,
    input  wire            rst_i,
    input  wire            wb_cyc_i,
    input  wire            wb_stb_i,
    input  wire            wb_we_i,
    input  wire [7:0]      wb_adr_i,
    input  wire [3:0]      wb_sel_i,
    input  wire [31:0]     wb_dat_i,
    output reg  [31:0]     wb_dat_o,
    output reg             wb_ack_o,
    // Status and strobes from the transfer engine
    input  wire [NCH-1:0]  count_done_i,
    input  wire [NCH-1:0]  xfer_abort_i,
    input  wire            addr_fault_i,
    input  wire            nmi_i,
    input  wire [NCH-1:0]  single_addr_i,
    input  wire [NCH-1:0]  dev_to_mem_i,
    input  wire [NCH-1:0]  read_phase_i,
    input  wire [NCH-1:0]  ack_req_i,
    input  wire [NCH-1:0]  accept_req_i,
    // Channel state, strobes and decoded fields
    output reg  [NCH-1:0]  channel_active_o,
    output reg  [NCH-1:0]  xfer_end_irq_o,
    output reg  [NCH-1:0]  queue_flush_o,
    output reg  [NCH-1:0]  transfer_ack_out_o,
    output reg  [NCH-1:0]  ondemand_ack_out_o,
    output reg  [NCH-1:0]  request_accept_out_o,
    output reg  [NCH-1:0]  request_sample_edge_o,
    output reg  [NCH*2-1:0] dest_step_o,
    output reg  [NCH*2-1:0] src_step_o,
    output reg  [NCH*4-1:0] request_source_sel_o,
    output reg  [NCH-1:0]  burst_or_steal_o,
    output reg  [NCH*3-1:0] access_size_o,
    output reg  [NCH*3-1:0] src_space_attr_o,
    output reg  [NCH*3-1:0] dst_space_attr_o,
    output reg  [NCH-1:0]  src_wait_reg_sel_o,
    output reg  [NCH-1:0]  dst_wait_reg_sel_o,
    // Mode copies
    output reg             ondemand_mode_o,
    output reg             eight_channel_select_o
);

    // Channel control storage and controller-wide operation bits
    reg [31:0]    channel_control_reg [0:NCH-1];
    reg [31:0]    dma_operation_reg;
    reg [NCH-1:0] done_seen_reg;
    reg           ae_seen_reg;
    reg           nmi_seen_reg;

    // Decode of the request in flight
    wire       req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       full_w   = (wb_sel_i == 4'hF);
    wire       wr       = req & wb_we_i & full_w;
    wire       is_ch    = (wb_adr_i[7:5] == 3'h0);
    wire [2:0] ch_idx   = wb_adr_i[4:2];
    wire       is_oper  = (wb_adr_i == `DCC_OPER_OFF);
    wire       is_stat  = (wb_adr_i == `DCC_CHSTAT_OFF);

    // Operation register fields used below
    wire       ondemand_mode      = dma_operation_reg[`DCC_OPER_DDT_BIT];
    wire       eight_channel_select      = dma_operation_reg[`DCC_OPER_DBL_BIT];
    wire       master_on      = dma_operation_reg[`DCC_OPER_DME_BIT];
    wire       ae       = dma_operation_reg[`DCC_OPER_AE_BIT];
    wire       nmi_seen_flag     = dma_operation_reg[`DCC_OPER_NMI_SEEN_FLAG_BIT];

    // Writable-bit mask per channel; low channels keep polarity bits
    // Channels 2-7 lose bits 18 and 16; all lose 23:20 and 3
    function [31:0] ch_mask;
        input integer idx;
        begin
            ch_mask = (idx < 2) ? `DCC_LO_CH_MASK : `DCC_HI_CH_MASK;
        end
    endfunction

    // Apply a write to a sticky flag: zero clears only if read as one before
    // Shared by the done flag and both fault flags so they behave alike
    function flag_next;
        input cur;
        input seen;
        input wbit;
        input hw_set;
        begin
            if (hw_set)
                flag_next = 1'b1;           // set wins over clear
            else if (!wbit && seen)
                flag_next = 1'b0;
            else
                flag_next = cur;
        end
    endfunction

    // Loop indices, one per process, and read-side scratch
    integer i;
    integer j;
    reg [31:0] rd_val;
    reg [NCH-1:0] stat_val;

    // Read data mux; narrow reads give zero
    always @* begin
        rd_val   = 32'h00000000;
        // Unmapped addresses fall through to zero
        stat_val = channel_active_o;
        if (full_w) begin
            if (is_ch)
                rd_val = channel_control_reg[ch_idx] & ch_mask(ch_idx);
            else if (is_oper)
                rd_val = dma_operation_reg;
            else if (is_stat)
                rd_val = {{(32-NCH){1'b0}}, stat_val};
        end
    end

    // Bus answer: one-cycle ack, data registered with it
    // A request is taken where cyc and stb are high and ack is low;
    // ack rises one cycle later and stands for one cycle. Masking req
    // with ack keeps a held request from being taken twice, so the
    // master must drop cyc and stb on the edge that sees ack.
    // Read data is zero outside the ack cycle to ease bus muxing.
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= (req && !wb_we_i) ? rd_val : 32'h00000000;
        end
    end

    // Read-one tracking for write-zero-to-clear flags
    // Only a full-word read arms a clear; a narrow read returns zero
    // and so never showed the flag to software
    always @(posedge clk_i) begin
        if (rst_i) begin
            done_seen_reg <= {NCH{1'b0}};
            ae_seen_reg   <= 1'b0;
            nmi_seen_reg  <= 1'b0;
        end else if (req && !wb_we_i && full_w) begin
            if (is_ch)
                done_seen_reg[ch_idx] <= channel_control_reg[ch_idx][`DCC_TE_BIT];
            if (is_oper) begin
                ae_seen_reg  <= ae;
                nmi_seen_reg <= nmi_seen_flag;
            end
        end
    end

    // Operation register: enables, mode bits, fault flags
    // Fault inputs set their flags even with the master enable off,
    // and a set flag holds every channel idle until it is cleared
    always @(posedge clk_i) begin
        if (rst_i) begin
            dma_operation_reg <= `DCC_OPER_RESET;
        end else begin
            if (wr && is_oper)
                dma_operation_reg <= (wb_dat_i & `DCC_OPER_MASK) |
                    {29'h0, flag_next(ae, ae_seen_reg, wb_dat_i[`DCC_OPER_AE_BIT], addr_fault_i),
                     flag_next(nmi_seen_flag, nmi_seen_reg, wb_dat_i[`DCC_OPER_NMI_SEEN_FLAG_BIT], nmi_i), 1'b0};
            else begin
                if (addr_fault_i)
                    dma_operation_reg[`DCC_OPER_AE_BIT] <= 1'b1;
                if (nmi_i)
                    dma_operation_reg[`DCC_OPER_NMI_SEEN_FLAG_BIT] <= 1'b1;
            end
        end
    end

    // Channel registers; held across low-power modes since nothing but reset clears them
    // Own loop index, so no two processes share a variable
    // The done bit is handled apart from the word: software may only
    // clear it, and a completion in the same cycle must win
    always @(posedge clk_i) begin
        if (rst_i) begin
            for (j = 0; j < NCH; j = j + 1)
                channel_control_reg[j] <= `DCC_CHCTL_RESET;
        end else begin
            for (j = 0; j < NCH; j = j + 1) begin
                if (wr && is_ch && ch_idx == j) begin
                    // Reserved, flush and fixed bits are masked before storing
                    channel_control_reg[j] <= (wb_dat_i & ch_mask(j)) & ~(32'h1 << `DCC_TE_BIT);
                    channel_control_reg[j][`DCC_TE_BIT] <= flag_next(channel_control_reg[j][`DCC_TE_BIT],
                        done_seen_reg[j], wb_dat_i[`DCC_TE_BIT],
                        count_done_i[j] & ~xfer_abort_i[j]);
                end else if (count_done_i[j] && !xfer_abort_i[j]) begin
                    // An aborted run reports no completion
                    channel_control_reg[j][`DCC_TE_BIT] <= 1'b1;
                end
            end
        end
    end

    // Per-channel decoded outputs, all registered
    // Outputs sit at zero in reset and take the fields one cycle later
    always @(posedge clk_i) begin
        if (rst_i) begin
            channel_active_o      <= {NCH{1'b0}};
            xfer_end_irq_o        <= {NCH{1'b0}};
            queue_flush_o         <= {NCH{1'b0}};
            transfer_ack_out_o    <= {NCH{1'b0}};
            ondemand_ack_out_o    <= {NCH{1'b0}};
            request_accept_out_o  <= {NCH{1'b0}};
            request_sample_edge_o <= {NCH{1'b0}};
            dest_step_o           <= {(NCH*2){1'b0}};
            src_step_o            <= {(NCH*2){1'b0}};
            request_source_sel_o  <= {(NCH*4){1'b0}};
            burst_or_steal_o      <= {NCH{1'b0}};
            access_size_o         <= {(NCH*3){1'b0}};
            src_space_attr_o      <= {(NCH*3){1'b0}};
            dst_space_attr_o      <= {(NCH*3){1'b0}};
            src_wait_reg_sel_o    <= {NCH{1'b0}};
            dst_wait_reg_sel_o    <= {NCH{1'b0}};
            ondemand_mode_o       <= 1'b0;
            eight_channel_select_o <= 1'b0;
        end else begin
            // Mode copies for the arbiter and strobe logic
            ondemand_mode_o        <= ondemand_mode;
            eight_channel_select_o <= eight_channel_select;

            for (i = 0; i < NCH; i = i + 1) begin
                // Enable needs both enables, no done flag, no fault
                // Faults stop every channel at once, as the flags are shared
                channel_active_o[i] <= channel_control_reg[i][`DCC_DE_BIT] & master_on & ~ae & ~nmi_seen_flag &
                                       ~channel_control_reg[i][`DCC_TE_BIT];

                // Level request; stays up until the done flag is cleared
                xfer_end_irq_o[i] <= channel_control_reg[i][`DCC_IE_BIT] &
                                     channel_control_reg[i][`DCC_TE_BIT];

                // Flush pulse only; the bit itself is never stored
                // Only a full-word write fires it, since wr checks sel
                queue_flush_o[i] <= wr & is_ch & (ch_idx == i) & wb_dat_i[`DCC_QCL_BIT] & ondemand_mode & eight_channel_select;

                // Normal mode: polarity only on channels 0-1; ack only when phase matches or the channel is single-address
                // Upper channels have no pin in normal mode: they pass the
                // request through active high and go quiet in on-demand mode
                transfer_ack_out_o[i] <= ((!ondemand_mode && i < 2) ?
                    ((ack_req_i[i] & (single_addr_i[i] |
                      (read_phase_i[i] ^ channel_control_reg[i][`DCC_AM_BIT])))
                      ^ ~channel_control_reg[i][`DCC_AL_BIT])
                    : (ack_req_i[i] & !ondemand_mode));

                // On-demand acknowledge is active high; polarity bit ignored
                ondemand_ack_out_o[i] <= ondemand_mode & ack_req_i[i] & (single_addr_i[i] |
                    (read_phase_i[i] ^ channel_control_reg[i][`DCC_AM_BIT]));

                // Accept strobe takes polarity on the same channels and mode; elsewhere it passes the request through, on-demand mode too
                request_accept_out_o[i] <= (!ondemand_mode && i < 2) ?
                    (accept_req_i[i] ^ ~channel_control_reg[i][`DCC_RL_BIT]) : accept_req_i[i];

                // Forced low where the channel has no request pin
                request_sample_edge_o[i] <= (ondemand_mode || i < 2) &
                    channel_control_reg[i][`DCC_DS_BIT];

                // Steps are zeroed where that address does not move
                dest_step_o[i*2 +: 2] <= (single_addr_i[i] && !dev_to_mem_i[i]) ? 2'h0 :
                    channel_control_reg[i][`DCC_DM_HI:`DCC_DM_LO];
                src_step_o[i*2 +: 2] <= (single_addr_i[i] && dev_to_mem_i[i]) ? 2'h0 :
                    channel_control_reg[i][`DCC_SM_HI:`DCC_SM_LO];

                // Plain field copies for the transfer engine
                request_source_sel_o[i*4 +: 4] <= channel_control_reg[i][`DCC_RS_HI:`DCC_RS_LO];
                burst_or_steal_o[i] <= channel_control_reg[i][`DCC_TM_BIT];
                access_size_o[i*3 +: 3] <= channel_control_reg[i][`DCC_TS_HI:`DCC_TS_LO];

                // Card-interface attributes; the bus unit applies them
                src_space_attr_o[i*3 +: 3] <= channel_control_reg[i][`DCC_SSA_HI:`DCC_SSA_LO];
                dst_space_attr_o[i*3 +: 3] <= channel_control_reg[i][`DCC_DSA_HI:`DCC_DSA_LO];
                src_wait_reg_sel_o[i] <= channel_control_reg[i][`DCC_STC_BIT];
                dst_wait_reg_sel_o[i] <= channel_control_reg[i][`DCC_DTC_BIT];
            end
        end
    end

endmodule

// *** tb/dcc_chk.sv ***
// Purpose: Port-level checks of the DMA channel control block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the design from the bench top file
`timescale 1ns/1ps
module dcc_chk #(
    parameter NCH = 8
) (
    input wire logic            clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input wire logic            ondemand_mode_o, eight_channel_select_o,
    input wire logic [7:0]      wb_adr_i,
    input wire logic [3:0]      wb_sel_i,
    input wire logic [31:0]     wb_dat_o,
    input wire logic [NCH-1:0]  channel_active_o, xfer_end_irq_o, queue_flush_o, request_sample_edge_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Request seen while no answer is pending
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // Answer is a single-cycle pulse
    sequence s_ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    AST_ACK_ONCE: assert property (s_req |=> s_ack_once)
        else $error("ack missing or too long");
    AST_SEL_ZERO: assert property (wb_ack_o && !wb_we_i && wb_sel_i != 4'hF |-> wb_dat_o == 32'h0)
        else $error("narrow read returned data");
    AST_RSV_ZERO: assert property (wb_ack_o |-> wb_dat_o[23:20] == 4'h0 && !wb_dat_o[3])
        else $error("reserved or flush bit read nonzero");
    AST_HI_CH_ZERO: assert property (wb_ack_o && !wb_we_i && wb_adr_i inside {[8'h08:8'h1C]}
        |-> !wb_dat_o[18] && !wb_dat_o[16])
        else $error("upper channel polarity bits read nonzero");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    AST_IRQ_BLOCKS: assert property (!(|(xfer_end_irq_o & channel_active_o)))
        else $error("channel active with done flag set");
    AST_FLUSH_MODE: assert property (|queue_flush_o |-> ondemand_mode_o && eight_channel_select_o)
        else $error("flush outside eight-channel on-demand mode");
    AST_FLUSH_PULSE: assert property (|queue_flush_o |=> queue_flush_o == '0)
        else $error("flush longer than one cycle");
    AST_EDGE_NORMAL: assert property (!ondemand_mode_o |-> request_sample_edge_o[NCH-1:2] == '0)
        else $error("sampling select leaked to upper channel");
endmodule

// *** tb/dcc_peer.sv ***
// Purpose: Stand-in for the transfer engine and external requesters
// Assumes: Eight channels, one clock
// Notes:   Finishes a count every eight beats while any channel runs
`timescale 1ns/1ps
module dcc_peer (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] active_i,
    input  wire logic       stop_i,
    output logic      [7:0] count_done_o,
    output logic      [7:0] xfer_abort_o,
    output logic      [7:0] ack_req_o,
    output logic      [7:0] accept_req_o,
    output logic      [7:0] read_phase_o
);
    logic [2:0] beat;
    // Short fixed count keeps the run brief
    always @(posedge clk_i) begin
        if (rst_i) begin
            beat         <= 3'h0;
            count_done_o <= 8'h00;
            read_phase_o <= 8'h00;
        end else begin
            beat         <= (|active_i) ? beat + 3'h1 : 3'h0;
            count_done_o <= (beat == 3'h7) ? active_i : 8'h00;
            read_phase_o <= ~read_phase_o;
        end
    end
    // Abort held as a level by the bench
    assign xfer_abort_o = {8{stop_i}};
    assign ack_req_o    = active_i & read_phase_o;
    assign accept_req_o = active_i;
endmodule

// *** tb/dcc_channel_control_tb_top.sv ***
// Purpose: Self-checking bench of the DMA channel control block
// Assumes: Classic Wishbone, 20 MHz clock
// Notes:   Register rows first, then flag, flush, polarity and abort cases
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module dcc_channel_control_tb_top;
    typedef struct packed {logic w; logic [7:0] a; logic [3:0] s; logic [31:0] d; logic [31:0] e;} dcc_row_t;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, addr_fault_i, nmi_i, stop;
    logic        ondemand_mode_o, eight_channel_select_o, pa;
    logic [7:0]  wb_adr_i, count_done_i, xfer_abort_i, single_addr_i, dev_to_mem_i, read_phase_i, ack_req_i;
    logic [7:0]  accept_req_i, channel_active_o, xfer_end_irq_o, queue_flush_o, transfer_ack_out_o, flushed;
    logic [7:0]  ondemand_ack_out_o, request_accept_out_o, request_sample_edge_o, burst_or_steal_o;
    logic [7:0]  src_wait_reg_sel_o, dst_wait_reg_sel_o;
    logic [15:0] dest_step_o, src_step_o;
    logic [23:0] access_size_o, src_space_attr_o, dst_space_attr_o;
    logic [31:0] wb_dat_i, wb_dat_o, request_source_sel_o, q;
    logic [3:0]  wb_sel_i;
    int          fail_count = 0, compares = 0, cycles = 0, n;
    dcc_row_t    rows[12];

    dcc_channel_control #(.NCH(8)) i_dut (.*);
    dcc_peer i_peer (.clk_i(clk_i), .rst_i(rst_i), .active_i(channel_active_o), .stop_i(stop),
        .count_done_o(count_done_i), .xfer_abort_o(xfer_abort_i), .ack_req_o(ack_req_i),
        .accept_req_o(accept_req_i), .read_phase_o(read_phase_i));

    task complete_run();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // One classic cycle; waits for ack, bounded only by the hang guard
    task bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= w; wb_adr_i <= a; wb_sel_i <= s; wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Sticky record of flush pulses; hang guard
    always @(posedge clk_i) begin
        flushed <= rst_i ? 8'h00 : flushed | queue_flush_o;
        cycles++;
        if (cycles == 3000) begin fail_count++; complete_run(); end
    end

    initial begin
        rst_i = 1'b1; wb_cyc_i = 0; wb_stb_i = 0; wb_we_i = 0; wb_adr_i = 0; wb_sel_i = 0; wb_dat_i = 0;
        addr_fault_i = 0; nmi_i = 0; single_addr_i = 0; dev_to_mem_i = 0; stop = 0;
        rows = '{'{0, 8'h00, 4'hF, 32'h0, 32'h0}, '{1, 8'h00, 4'hF, 32'hFFFFFFFF, 32'h0},
                 '{0, 8'h00, 4'hF, 32'h0, 32'hFF0FFFF5}, '{1, 8'h08, 4'hF, 32'hFFFFFFFE, 32'h0},
                 '{0, 8'h08, 4'hF, 32'h0, 32'hFF0AFFF4}, '{1, 8'h04, 4'h3, 32'hFFFFFFFF, 32'h0},
                 '{0, 8'h04, 4'hF, 32'h0, 32'h0}, '{0, 8'h00, 4'h3, 32'h0, 32'h0},
                 '{1, 8'h28, 4'hF, 32'hFFFFFFFF, 32'h0}, '{0, 8'h28, 4'hF, 32'h0, 32'h0},
                 '{1, 8'h20, 4'hF, 32'hFFFFFFFF, 32'h0}, '{0, 8'h20, 4'hF, 32'h0, 32'h0000C001}};
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].s, rows[i].d);
            if (!rows[i].w) `CHK(q, rows[i].e)
        end
        // Channel 0 runs to its count in on-demand mode
        n = 0;
        while (xfer_end_irq_o[0] !== 1'b1 && n < 60) begin @(posedge clk_i); n++; end
        `CHK(xfer_end_irq_o[0], 1'b1)
        `CHK({ondemand_mode_o, eight_channel_select_o}, 2'b11)
        bus(0, 8'h24, 4'hF, 0); `CHK(q, 32'h0)
        bus(0, 8'h00, 4'hF, 0); `CHK(q, 32'hFF0FFFF7)
        bus(1, 8'h00, 4'hF, 0); bus(0, 8'h00, 4'hF, 0); `CHK(q, 32'h0)
        // Flush acts only with both mode bits set
        bus(1, 8'h0C, 4'hF, 32'h8); repeat (3) @(posedge clk_i); `CHK(flushed, 8'h08)
        bus(1, 8'h20, 4'hF, 32'h1); bus(1, 8'h0C, 4'hF, 32'h8); repeat (3) @(posedge clk_i);
        `CHK(flushed, 8'h08)
        // Idle strobes in normal mode follow polarity bits
        repeat (2) @(posedge clk_i); `CHK({request_accept_out_o[0], transfer_ack_out_o[0]}, 2'b11)
        bus(1, 8'h00, 4'hF, 32'h00050000); repeat (2) @(posedge clk_i);
        `CHK({request_accept_out_o[0], transfer_ack_out_o[0]}, 2'b00)
        // Field copies reach the engine one cycle after the write
        bus(1, 8'h00, 4'hF, 32'hB60B9CD0); repeat (2) @(posedge clk_i);
        `CHK({src_space_attr_o[2:0], src_wait_reg_sel_o[0]}, 4'hB)
        `CHK({dst_space_attr_o[2:0], dst_wait_reg_sel_o[0]}, 4'h6)
        `CHK({dest_step_o[1:0], src_step_o[1:0], request_source_sel_o[3:0]}, 8'h9C)
        `CHK({burst_or_steal_o[0], access_size_o[2:0], request_sample_edge_o[0]}, 5'h1B)
        single_addr_i <= 8'h01; repeat (2) @(posedge clk_i);
        `CHK({dest_step_o[1:0], src_step_o[1:0]}, 4'h1)
        dev_to_mem_i <= 8'h01; repeat (2) @(posedge clk_i);
        `CHK({dest_step_o[1:0], src_step_o[1:0]}, 4'h8)
        single_addr_i <= 8'h00; dev_to_mem_i <= 8'h00;
        // Aborted run leaves the done flag clear
        stop <= 1'b1; bus(1, 8'h04, 4'hF, 32'h1);
        bus(0, 8'h24, 4'hF, 0); `CHK(q, 32'h2)
        // Channel 1 strobes are active low, ack in the read phase
        @(negedge clk_i); pa = ack_req_i[1] & read_phase_i[1];
        repeat (20) begin
            @(negedge clk_i);
            `CHK(transfer_ack_out_o[1], ~pa)
            `CHK({request_accept_out_o[1], ondemand_ack_out_o}, 9'h000)
            pa = ack_req_i[1] & read_phase_i[1];
        end
        bus(0, 8'h04, 4'hF, 0); `CHK(q, 32'h1)
        // Reset in mid-run clears everything
        rst_i <= 1'b1; repeat (3) @(posedge clk_i); rst_i <= 1'b0;
        bus(0, 8'h08, 4'hF, 0); `CHK(q, 32'h0)
        complete_run();
    end
endmodule
bind dcc_channel_control dcc_chk #(.NCH(NCH)) u_chk (.*);
